// >>> logic/e1_irq_pkg.sv
package e1_irq_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_ENABLE = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_BLOCK = 8'h08;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int BIT_LOF_STATE = 7;
  localparam int BIT_AIS_STATE = 6;
  localparam int BIT_MYEL = 5;
  localparam int BIT_SPARE4 = 4;
  localparam int BIT_LCV = 3;
  localparam int BIT_LOF = 2;
  localparam int BIT_AIS = 1;
  localparam int BIT_YEL = 0;
  localparam int BIT_RAI_STATE = 7;
  localparam int BIT_BLOCK_EN = 0;

  localparam logic [7:0] FLAG_MASK = 8'h2F;
  localparam logic [7:0] ENABLE_WR_MASK = 8'h3F;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic BLOCK_EN_RESET = 1'b0;

  // ************************************************************
  // Remote alarm timing
  // ************************************************************
  // Two non-FAS frames, about 375 us, to declare or clear
  localparam int RAI_TIME_US = 375;
  localparam logic [1:0] RAI_FRAMES = 2'h2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {SEL_STATUS, SEL_ENABLE, SEL_BLOCK, SEL_NONE} reg_sel_t;

  typedef struct packed {
    logic lcv;
    logic lof_state;
    logic ais_state;
    logic myel_state;
    logic nfas_strobe;
    logic a_bit;
  } rx_events_t;

  function automatic reg_sel_t decode_addr(input logic [ADDR_W-1:0] addr);
    if (addr[ADDR_W-1:2] == OFS_STATUS[ADDR_W-1:2]) begin
      return SEL_STATUS;
    end else if (addr[ADDR_W-1:2] == OFS_ENABLE[ADDR_W-1:2]) begin
      return SEL_ENABLE;
    end else if (addr[ADDR_W-1:2] == OFS_BLOCK[ADDR_W-1:2]) begin
      return SEL_BLOCK;
    end
    return SEL_NONE;
  endfunction

endpackage

// >>> logic/remote_alarm_detect.sv
`timescale 1ns/1ps
module remote_alarm_detect
  import e1_irq_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic nfas_strobe,
  input wire logic a_bit,
  output logic active_r
);

  logic last_a_r;
  logic last_a_nxt;
  logic [1:0] run_r;
  logic [1:0] run_nxt;
  logic active_nxt;

  // ************************************************************
  // Run of equal A bits over non-FAS frames
  // ************************************************************
  always_comb begin
    last_a_nxt = last_a_r;
    run_nxt = run_r;
    active_nxt = active_r;
    if (nfas_strobe) begin
      last_a_nxt = a_bit;
      if (run_r != 2'h0 && last_a_r == a_bit) begin
        if (run_r != RAI_FRAMES) begin
          run_nxt = run_r + 2'h1;
        end
      end else begin
        run_nxt = 2'h1;
      end
      if (run_nxt == RAI_FRAMES) begin
        active_nxt = a_bit;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_a_r <= 1'b0;
      run_r <= 2'h0;
      active_r <= 1'b0;
    end else begin
      last_a_r <= last_a_nxt;
      run_r <= run_nxt;
      active_r <= active_nxt;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Last A bit seen on a non-FAS frame, kept for the checks only
  logic chk_seen_r;
  logic chk_seen_nxt;
  logic chk_last_a_r;
  logic chk_last_a_nxt;

  always_comb begin
    chk_seen_nxt = chk_seen_r;
    chk_last_a_nxt = chk_last_a_r;
    if (nfas_strobe) begin
      chk_seen_nxt = 1'b1;
      chk_last_a_nxt = a_bit;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chk_seen_r <= 1'b0;
      chk_last_a_r <= 1'b0;
    end else begin
      chk_seen_r <= chk_seen_nxt;
      chk_last_a_r <= chk_last_a_nxt;
    end
  end

  sequence s_one_frame(logic v);
    nfas_strobe && a_bit == v;
  endsequence

  sequence s_second_frame(logic v);
    (chk_seen_r && chk_last_a_r == v) ##0 s_one_frame(v);
  endsequence

  AST_RAI_DECLARE: assert property (s_second_frame(1'b1) |=> active_r)
    else $error("remote alarm not declared after two A=1 frames");
  AST_RAI_CLEAR: assert property (s_second_frame(1'b0) |=> !active_r)
    else $error("remote alarm not cleared after two A=0 frames");
  AST_RAI_ONE_FRAME: assert property (nfas_strobe && !(chk_seen_r && chk_last_a_r == a_bit) |=> $stable(active_r))
    else $error("remote alarm changed after a single frame");
  AST_RAI_HOLD: assert property (!nfas_strobe |=> $stable(active_r))
    else $error("remote alarm changed without a frame");

endmodule

// >>> logic/e1_rx_alarm_error_irq.sv
// Implementation choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
module e1_rx_alarm_error_irq
  import e1_irq_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire rx_events_t rx_events,
  output logic irq_r
);

  // ************************************************************
  // Remote alarm detector
  // ************************************************************
  logic rai_active;

  remote_alarm_detect u_rai (
    .aclk(aclk),
    .aresetn(aresetn),
    .nfas_strobe(rx_events.nfas_strobe),
    .a_bit(rx_events.a_bit),
    .active_r(rai_active)
  );

  // ************************************************************
  // Write channel
  // ************************************************************
  logic awready_r, awready_nxt;
  logic wready_r, wready_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic [ADDR_W-1:0] waddr_r, waddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic wbyte0_r, wbyte0_nxt;
  logic aw_hs, w_hs, b_hs, do_write;
  reg_sel_t wsel;

  assign aw_hs = s_axi_awvalid && awready_r;
  assign w_hs = s_axi_wvalid && wready_r;
  assign b_hs = bvalid_r && s_axi_bready;
  // Both halves held and no response pending
  assign do_write = !awready_r && !wready_r && !bvalid_r;
  assign wsel = decode_addr(waddr_r);

  always_comb begin
    awready_nxt = awready_r;
    wready_nxt = wready_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    waddr_nxt = waddr_r;
    wdata_nxt = wdata_r;
    wbyte0_nxt = wbyte0_r;
    if (aw_hs) begin
      awready_nxt = 1'b0;
      waddr_nxt = s_axi_awaddr;
    end
    if (w_hs) begin
      wready_nxt = 1'b0;
      wdata_nxt = s_axi_wdata;
      wbyte0_nxt = s_axi_wstrb[0];
    end
    if (do_write) begin
      bvalid_nxt = 1'b1;
      bresp_nxt = (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
    if (b_hs) begin
      bvalid_nxt = 1'b0;
      awready_nxt = 1'b1;
      wready_nxt = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      waddr_r <= '0;
      wdata_r <= '0;
      wbyte0_r <= 1'b0;
    end else begin
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      waddr_r <= waddr_nxt;
      wdata_r <= wdata_nxt;
      wbyte0_r <= wbyte0_nxt;
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  // ************************************************************
  // Read channel
  // ************************************************************
  logic arready_r, arready_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [7:0] flags_r, flags_nxt;
  logic [7:0] enable_r, enable_nxt;
  logic block_en_r, block_en_nxt;
  logic lof_last_r, ais_last_r, myel_last_r, rai_last_r;
  logic ar_hs, r_hs, status_read;
  reg_sel_t rsel;
  logic [7:0] status_view, enable_view;

  assign ar_hs = s_axi_arvalid && arready_r;
  assign r_hs = rvalid_r && s_axi_rready;
  assign rsel = decode_addr(s_axi_araddr);
  assign status_read = ar_hs && rsel == SEL_STATUS;

  always_comb begin
    status_view = flags_r & FLAG_MASK;
    status_view[BIT_LOF_STATE] = rx_events.lof_state;
    status_view[BIT_AIS_STATE] = rx_events.ais_state;
    enable_view = enable_r & ENABLE_WR_MASK;
    enable_view[BIT_RAI_STATE] = rai_active;
  end

  always_comb begin
    arready_nxt = arready_r;
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    if (ar_hs) begin
      arready_nxt = 1'b0;
      rvalid_nxt = 1'b1;
      rresp_nxt = RESP_OKAY;
      rdata_nxt = '0;
      unique case (rsel)
        SEL_STATUS: rdata_nxt[7:0] = status_view;
        SEL_ENABLE: rdata_nxt[7:0] = enable_view;
        SEL_BLOCK: rdata_nxt[BIT_BLOCK_EN] = block_en_r;
        SEL_NONE: rresp_nxt = RESP_SLVERR;
      endcase
    end
    if (r_hs) begin
      rvalid_nxt = 1'b0;
      arready_nxt = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rresp_r <= RESP_OKAY;
      rdata_r <= '0;
    end else begin
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;

  // ************************************************************
  // Event flags, enables and interrupt
  // ************************************************************
  logic [7:0] set_vec;
  logic irq_nxt;

  always_comb begin
    set_vec = '0;
    set_vec[BIT_LCV] = rx_events.lcv;
    set_vec[BIT_LOF] = rx_events.lof_state != lof_last_r;
    set_vec[BIT_AIS] = rx_events.ais_state != ais_last_r;
    set_vec[BIT_YEL] = rai_active != rai_last_r;
    set_vec[BIT_MYEL] = rx_events.myel_state != myel_last_r;
    // A read clears, but a new event in the same cycle survives
    flags_nxt = flags_r;
    if (status_read) begin
      flags_nxt = '0;
    end
    flags_nxt = (flags_nxt | set_vec) & FLAG_MASK;
    enable_nxt = enable_r;
    block_en_nxt = block_en_r;
    if (do_write && wbyte0_r) begin
      if (wsel == SEL_ENABLE) begin
        // Spare bit 4 is stored as written; software keeps it 0
        enable_nxt = wdata_r[7:0] & ENABLE_WR_MASK;
      end
      if (wsel == SEL_BLOCK) begin
        block_en_nxt = wdata_r[BIT_BLOCK_EN];
      end
    end
    irq_nxt = block_en_r && |(flags_r & enable_r & FLAG_MASK);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_r <= FLAGS_RESET;
      enable_r <= ENABLE_RESET;
      block_en_r <= BLOCK_EN_RESET;
      lof_last_r <= 1'b0;
      ais_last_r <= 1'b0;
      myel_last_r <= 1'b0;
      rai_last_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      flags_r <= flags_nxt;
      enable_r <= enable_nxt;
      block_en_r <= block_en_nxt;
      lof_last_r <= rx_events.lof_state;
      ais_last_r <= rx_events.ais_state;
      myel_last_r <= rx_events.myel_state;
      rai_last_r <= rai_active;
      irq_r <= irq_nxt;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_status_read_quiet(int b);
    status_read && !set_vec[b];
  endsequence

  sequence s_gated(int b);
    block_en_r && enable_r[b] && flags_r[b];
  endsequence

  AST_LCV_SET: assert property (rx_events.lcv |=> flags_r[BIT_LCV] ##1
    (irq_r || !$past(enable_r[BIT_LCV]) || !$past(block_en_r)))
    else $error("line violation did not set its flag");
  AST_LCV_CLEAR: assert property (s_status_read_quiet(BIT_LCV) |=> !flags_r[BIT_LCV])
    else $error("line violation flag not cleared by read");
  // Read clears the LOF, AIS and YEL change flags unless they are raised again
  AST_LOF_CLEAR: assert property (s_status_read_quiet(BIT_LOF) |=> !flags_r[BIT_LOF])
    else $error("frame loss change flag not cleared by read");
  AST_AIS_CLEAR: assert property (s_status_read_quiet(BIT_AIS) |=> !flags_r[BIT_AIS])
    else $error("alarm indication change flag not cleared by read");
  AST_YEL_CLEAR: assert property (s_status_read_quiet(BIT_YEL) |=> !flags_r[BIT_YEL])
    else $error("remote alarm change flag not cleared by read");
  AST_LOF_EDGE: assert property ($changed(rx_events.lof_state) |=> flags_r[BIT_LOF])
    else $error("frame loss change not flagged");
  AST_AIS_EDGE: assert property ($changed(rx_events.ais_state) |=> flags_r[BIT_AIS])
    else $error("alarm indication change not flagged");
  AST_YEL_EDGE: assert property ($changed(rai_active) |=> flags_r[BIT_YEL])
    else $error("remote alarm change not flagged");
  AST_RAI_READBACK: assert property (ar_hs && rsel == SEL_ENABLE |=> rdata_r[BIT_RAI_STATE] == $past(rai_active))
    else $error("enable bit 7 does not show remote alarm");
  AST_LCV_IRQ: assert property (s_gated(BIT_LCV) |=> irq_r)
    else $error("enabled line violation gave no interrupt");
  AST_LOF_IRQ: assert property (s_gated(BIT_LOF) |=> irq_r)
    else $error("enabled frame loss change gave no interrupt");
  AST_MYEL_IRQ: assert property (s_gated(BIT_MYEL) |=> irq_r)
    else $error("enabled multiframe alarm gave no interrupt");
  AST_AIS_IRQ: assert property (s_gated(BIT_AIS) |=> irq_r)
    else $error("enabled alarm indication gave no interrupt");
  AST_YEL_IRQ: assert property (s_gated(BIT_YEL) |=> irq_r)
    else $error("enabled remote alarm change gave no interrupt");
  AST_BLOCK_OFF: assert property (!block_en_r |=> !irq_r)
    else $error("interrupt while block enable is 0");
  AST_MASKED: assert property ((flags_r & enable_r) == 8'h00 |=> !irq_r)
    else $error("interrupt with no enabled flag");

endmodule

// >>> tb/tb_e1_rx_alarm_error_irq.sv
`timescale 1ns/1ps
module tb_e1_rx_alarm_error_irq;
  import e1_irq_pkg::*;
  // ************************************************************
  // Signals and model state
  // ************************************************************
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [ADDR_W-1:0] awaddr = '0;
  logic [ADDR_W-1:0] araddr = '0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, irq_r;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = 4'hF;
  logic [31:0] rdata;
  logic [1:0] bresp, rresp, r;
  logic [31:0] d;
  rx_events_t ev = '0;
  logic [7:0] m_flags = '0, m_en = '0;
  logic m_blk = 1'h0, m_rai = 1'h0;
  logic [31:0] rng = 32'h329F;
  int n_fail = 0, n_tests = 0, k;

  always #20 aclk = ~aclk;

  e1_rx_alarm_error_irq dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .rx_events(ev), .irq_r(irq_r));

  // ************************************************************
  // Expectations and checks
  // ************************************************************
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic int fbit(input int kk);
    return (kk == 0) ? BIT_LCV : (kk == 1) ? BIT_LOF : (kk == 2) ? BIT_AIS : BIT_MYEL;
  endfunction
  function automatic logic exp_irq();
    return m_blk & (|(m_flags & m_en & FLAG_MASK));
  endfunction
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t data got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t irq got %b exp %b", $time, got, exp);
    end
  endtask
  task automatic chk_irq();
    repeat (2) @(posedge aclk);
    chk_bit(irq_r, exp_irq());
  endtask

  // ************************************************************
  // Bus master
  // ************************************************************
  task automatic axi_wr(input logic [7:0] a, input logic [7:0] v, output logic [1:0] rs);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, v};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    rs = bresp;
    bready <= 1'h0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    v = rdata;
    rs = rresp;
    rready <= 1'h0;
  endtask
  task automatic rd_stat();
    axi_rd(OFS_STATUS, d, r);
    chk_val({30'h0, r}, {30'h0, RESP_OKAY});
    chk_val(d, {24'h0, ev.lof_state, ev.ais_state, m_flags[5:0]});
    m_flags = '0;
  endtask
  task automatic rd_en();
    axi_rd(OFS_ENABLE, d, r);
    chk_val(d, {24'h0, m_rai, 1'h0, m_en[5:0]});
  endtask
  task automatic wr_en(input logic [7:0] v);
    axi_wr(OFS_ENABLE, v, r);
    chk_val({30'h0, r}, {30'h0, RESP_OKAY});
    m_en = v & ENABLE_WR_MASK;
  endtask

  // ************************************************************
  // Event drivers
  // ************************************************************
  task automatic fire(input int kk);
    case (kk)
      0: begin
        ev.lcv <= 1'h1;
        @(posedge aclk);
        ev.lcv <= 1'h0;
      end
      1: ev.lof_state <= ~ev.lof_state;
      2: ev.ais_state <= ~ev.ais_state;
      default: ev.myel_state <= ~ev.myel_state;
    endcase
    m_flags[fbit(kk)] = 1'h1;
    repeat (3) @(posedge aclk);
  endtask
  task automatic nfas(input logic a);
    ev.nfas_strobe <= 1'h1;
    ev.a_bit <= a;
    @(posedge aclk);
    ev.nfas_strobe <= 1'h0;
    ev.a_bit <= ~a;
    repeat (3) @(posedge aclk);
  endtask

  task automatic give_verdict();
    $display("checks %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    give_verdict();
  end

  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rd_stat();
    rd_en();
    axi_rd(OFS_BLOCK, d, r);
    chk_val(d, 32'h0);
    chk_irq();
    axi_rd(8'h0C, d, r);
    chk_val({30'h0, r}, {30'h0, RESP_SLVERR});
    chk_val(d, 32'h0);
    axi_wr(8'h0C, 8'hFF, r);
    chk_val({30'h0, r}, {30'h0, RESP_SLVERR});
    wstrb <= 4'h0;
    axi_wr(OFS_ENABLE, 8'h2F, r);
    wstrb <= 4'hF;
    chk_val({30'h0, r}, {30'h0, RESP_OKAY});
    rd_en();
    $display("test reset_map done");
    wr_en(8'hEF);
    rd_en();
    axi_wr(OFS_BLOCK, 8'h01, r);
    m_blk = 1'h1;
    for (k = 0; k < 4; k++) begin
      wr_en(8'h01 << fbit(k));
      fire(k);
      chk_irq();
      rd_stat();
      chk_irq();
      wr_en(8'h2F ^ (8'h01 << fbit(k)));
      fire(k);
      chk_irq();
      rd_stat();
    end
    $display("test sources done");
    wr_en(8'h01);
    nfas(1'h1);
    rd_en();
    nfas(1'h1);
    m_rai = 1'h1;
    m_flags[BIT_YEL] = 1'h1;
    rd_en();
    chk_irq();
    rd_stat();
    nfas(1'h0);
    nfas(1'h1);
    nfas(1'h0);
    rd_en();
    nfas(1'h0);
    m_rai = 1'h0;
    m_flags[BIT_YEL] = 1'h1;
    rd_en();
    rd_stat();
    $display("test remote_alarm done");
    axi_wr(OFS_BLOCK, 8'h00, r);
    m_blk = 1'h0;
    wr_en(8'h2F);
    fire(0);
    chk_irq();
    axi_wr(OFS_BLOCK, 8'h01, r);
    m_blk = 1'h1;
    chk_irq();
    rd_stat();
    $display("test block_gate done");
    repeat (40) begin
      rng = xs(rng);
      wr_en(rng[7:0] & 8'h2F);
      fire(int'(rng[9:8]));
      chk_irq();
      if (rng[10]) rd_stat();
      chk_irq();
    end
    $display("test random done");
    give_verdict();
  end
endmodule
